// >>> include/key_guard_pkg.sv
// Purpose: Shared types and constants for the key guard and self-test block
// Assumes: Single 10 MHz clock
// Notes: Slot and check numbering is fixed by this block
package key_guard_pkg;
    localparam int KEY_W = 256;
    localparam int SLOT_N = 4;
    localparam int SLOT_W = 2;
    localparam int FIFO_N = 4;
    localparam int CHECK_N = 9;
    localparam int CHECK_W = 4;
    localparam logic [SLOT_W-1:0] SLOT_AES = 2'h0;
    localparam logic [SLOT_W-1:0] SLOT_TDES = 2'h1;
    localparam logic [SLOT_W-1:0] SLOT_HMAC = 2'h2;
    localparam logic [SLOT_W-1:0] SLOT_CMAC = 2'h3;
    localparam logic [KEY_W-1:0] KEY_CLEAR = '0;
    localparam logic [CHECK_W-1:0] CHECK_LAST = 4'h8;
    // Check order: aes ccm enc/dec, aes ecb enc/dec, tdes ecb enc/dec,
    // hmac sha1, hmac sha256, aes cmac
    localparam logic [CHECK_N-1:0] CHECK_RESET = 9'h000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN = 4'h2,
        ST_PASS = 4'h4,
        ST_LOCK = 4'h8
    } test_state_t;

    typedef struct packed {
        logic valid;
        logic legacy;
        logic [SLOT_W-1:0] slot;
        logic [KEY_W-1:0] data;
    } key_write_t;

    typedef struct packed {
        logic valid;
        logic [SLOT_W-1:0] slot;
        logic [FIFO_N-1:0] fifo;
        logic [KEY_W-1:0] data;
    } fifo_write_t;

    typedef struct packed {
        logic start;
        logic [CHECK_W-1:0] index;
    } check_req_t;
endpackage

// >>> logic/key_guard.sv
// Purpose: Key store guard and power-up self-test sequencer
// Assumes: Known-answer engines outside answer start with done and pass
// Notes: No read path reaches a secret; keys leave only to the datapath
// Summary of operation
// - Keys load only via key registers or assigned FIFO
// - Writes to unassigned FIFO are discarded
// - Reads of secrets always return zeros
// - Reset event clears key store and legacy registers
// - New key fully replaces previous slot key
// - Self-test starts alone at power-up, pass/fail
// - Fail locks engine, pass makes it operational
// - Reset event reruns full self-test sequence
// - Tests run one at a time; access after all pass
// - Locked engine ignores all but reset
// - Nine known-answer checks cover all approved algorithms
`timescale 1ns/1ps
module key_guard (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic reset_event,
    // Key entry
    input wire key_guard_pkg::key_write_t key_wr,
    input wire key_guard_pkg::fifo_write_t fifo_wr,
    input wire logic [key_guard_pkg::FIFO_N-1:0] fifo_assigned,
    // Secret read port
    input wire logic key_rd,
    input wire logic [key_guard_pkg::SLOT_W-1:0] key_rd_slot,
    output logic [key_guard_pkg::KEY_W-1:0] key_rd_data,
    // Known-answer check engines
    output key_guard_pkg::check_req_t check_req,
    input wire logic check_done,
    input wire logic check_pass,
    // Service
    input wire logic service_req,
    output logic service_grant,
    output logic busy,
    output logic ready,
    output logic locked,
    output logic [key_guard_pkg::CHECK_N-1:0] checks_passed,
    output logic write_refused,
    // Key use by datapath
    output logic [key_guard_pkg::KEY_W-1:0] aes_key,
    output logic [key_guard_pkg::KEY_W-1:0] tdes_key,
    output logic [key_guard_pkg::KEY_W-1:0] hmac_key,
    output logic [key_guard_pkg::KEY_W-1:0] cmac_key
);
    key_guard_pkg::test_state_t state;
    key_guard_pkg::test_state_t next_state;
    logic [key_guard_pkg::KEY_W-1:0] store [key_guard_pkg::SLOT_N];
    logic [key_guard_pkg::KEY_W-1:0] legacy [key_guard_pkg::SLOT_N];
    logic [key_guard_pkg::CHECK_W-1:0] index;

    // A reset event outranks any write or request on the same edge,
    // so nothing taken in that cycle survives the wipe
    wire open_w = (state == key_guard_pkg::ST_PASS);
    wire take_w = open_w && !reset_event;
    wire reg_ok = take_w && key_wr.valid;
    wire fifo_hit = |(fifo_wr.fifo & fifo_assigned);
    wire fifo_ok = take_w && fifo_wr.valid && fifo_hit;
    wire fifo_bad = fifo_wr.valid && !fifo_ok;
    wire reg_bad = key_wr.valid && !reg_ok;
    wire last_w = (index == key_guard_pkg::CHECK_LAST);
    wire start_w = (state == key_guard_pkg::ST_IDLE);

    // Status decode from the state about to be entered; refusal from writes in the current state
    wire next_busy = (next_state == key_guard_pkg::ST_RUN) ||
        (next_state == key_guard_pkg::ST_IDLE);
    wire next_ready = (next_state == key_guard_pkg::ST_PASS);
    wire next_locked = (next_state == key_guard_pkg::ST_LOCK);
    wire next_refused = fifo_bad || reg_bad;

    // A run ends in pass only after the last check; any failure locks
    always_comb begin
        next_state = state;
        case (state)
            key_guard_pkg::ST_IDLE: next_state = key_guard_pkg::ST_RUN;
            key_guard_pkg::ST_RUN: begin
                if (check_done && !check_pass) begin
                    next_state = key_guard_pkg::ST_LOCK;
                end else if (check_done && last_w) begin
                    next_state = key_guard_pkg::ST_PASS;
                end
            end
            key_guard_pkg::ST_PASS: next_state = key_guard_pkg::ST_PASS;
            // Only a reset event or rst_b leaves the lock
            key_guard_pkg::ST_LOCK: next_state = key_guard_pkg::ST_LOCK;
            default: next_state = key_guard_pkg::ST_LOCK;
        endcase
        if (reset_event) begin
            next_state = key_guard_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= key_guard_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Sequencer decode: a result counts only while a run is open
    wire step_ok = (state == key_guard_pkg::ST_RUN) && check_done &&
        check_pass;
    wire step_next = step_ok && !last_w;
    wire restart_w = reset_event || start_w;
    wire [key_guard_pkg::CHECK_W-1:0] next_index = index + 4'h1;

    // Index steps once per passed check before the last; restarts at every run
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            index <= '0;
            checks_passed <= key_guard_pkg::CHECK_RESET;
        end else if (restart_w) begin
            index <= '0;
            checks_passed <= key_guard_pkg::CHECK_RESET;
        end else if (step_ok) begin
            checks_passed[index] <= 1'b1;
            if (!last_w) begin
                index <= next_index;
            end
        end
    end

    // One start pulse per check; a reset event holds it off a cycle
    // so that the new run always begins from the idle state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            check_req <= '0;
        end else if (restart_w) begin
            check_req.start <= !reset_event;
            check_req.index <= '0;
        end else begin
            check_req.start <= step_next;
            if (step_next) begin
                check_req.index <= next_index;
            end
        end
    end

    // Secrets: cleared on reset event, replaced whole on write; a write
    // never merges with the old key, so no stale bits outlive it
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < key_guard_pkg::SLOT_N; i++) begin
                store[i] <= key_guard_pkg::KEY_CLEAR;
                legacy[i] <= key_guard_pkg::KEY_CLEAR;
            end
        end else if (reset_event) begin
            for (int i = 0; i < key_guard_pkg::SLOT_N; i++) begin
                store[i] <= key_guard_pkg::KEY_CLEAR;
                legacy[i] <= key_guard_pkg::KEY_CLEAR;
            end
        end else begin
            if (reg_ok && key_wr.legacy) begin
                legacy[key_wr.slot] <= key_wr.data;
            end else if (reg_ok) begin
                store[key_wr.slot] <= key_wr.data;
            end
            if (fifo_ok) begin
                store[fifo_wr.slot] <= fifo_wr.data;
            end
        end
    end

    // Legacy register set wins over key store when non-zero
    wire [key_guard_pkg::KEY_W-1:0] sel_key [key_guard_pkg::SLOT_N];
    // Datapath copy is zero unless operational, so a reset event also
    // wipes the copies that the cipher engines hold
    wire [key_guard_pkg::KEY_W-1:0] out_key [key_guard_pkg::SLOT_N];
    genvar g;
    generate
        for (g = 0; g < key_guard_pkg::SLOT_N; g++) begin : g_sel
            assign sel_key[g] = (|legacy[g]) ? legacy[g] : store[g];
            assign out_key[g] = take_w ? sel_key[g] :
                key_guard_pkg::KEY_CLEAR;
        end
    endgenerate

    // Status flags follow the state about to be entered
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b1;
            ready <= 1'b0;
            locked <= 1'b0;
        end else begin
            busy <= next_busy;
            ready <= next_ready;
            locked <= next_locked;
        end
    end

    // Bus answers: the read address is never decoded, so no path
    // joins a stored secret to the read data
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            key_rd_data <= key_guard_pkg::KEY_CLEAR;
            service_grant <= 1'b0;
            write_refused <= 1'b0;
        end else begin
            key_rd_data <= key_guard_pkg::KEY_CLEAR;
            service_grant <= service_req && take_w;
            write_refused <= next_refused;
        end
    end

    // Keys reach the datapath only while operational
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aes_key <= key_guard_pkg::KEY_CLEAR;
            tdes_key <= key_guard_pkg::KEY_CLEAR;
            hmac_key <= key_guard_pkg::KEY_CLEAR;
            cmac_key <= key_guard_pkg::KEY_CLEAR;
        end else begin
            aes_key <= out_key[key_guard_pkg::SLOT_AES];
            tdes_key <= out_key[key_guard_pkg::SLOT_TDES];
            hmac_key <= out_key[key_guard_pkg::SLOT_HMAC];
            cmac_key <= out_key[key_guard_pkg::SLOT_CMAC];
        end
    end
endmodule

// >>> sim/key_guard_sva.sv
// Purpose: Port assertions for the key guard
// Assumes: One clock, rst_b async active low
// Notes: Legacy slots stay clear while store keys are checked
`timescale 1ns/1ps
module key_guard_sva (
    // Watched ports
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic reset_event,
    input wire key_guard_pkg::key_write_t key_wr,
    input wire key_guard_pkg::fifo_write_t fifo_wr,
    input wire logic [key_guard_pkg::FIFO_N-1:0] fifo_assigned,
    input wire logic [key_guard_pkg::KEY_W-1:0] key_rd_data,
    input wire key_guard_pkg::check_req_t check_req,
    input wire logic check_done,
    input wire logic check_pass,
    input wire logic service_req,
    input wire logic service_grant,
    input wire logic busy,
    input wire logic ready,
    input wire logic locked,
    input wire logic write_refused,
    input wire logic [key_guard_pkg::KEY_W-1:0] aes_key
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic go = ready && !reset_event;
    wire logic ok = check_done && check_pass && !reset_event;
    sequence s_take;
        go && key_wr.valid && !key_wr.legacy && key_wr.slot == 2'h0;
    endsequence
    property p_key;
        s_take ##1 !reset_event [*2] |=> aes_key == $past(key_wr.data, 3);
    endproperty
    property p_next;
        ok && check_req.index != key_guard_pkg::CHECK_LAST |=>
            check_req.start && check_req.index == $past(check_req.index) + 4'h1;
    endproperty
    property p_done;
        ok && check_req.index == key_guard_pkg::CHECK_LAST |=> ready && !busy;
    endproperty
    property p_lock;
        check_done && !check_pass && !reset_event |=> locked && !ready;
    endproperty
    property p_hold; locked && !reset_event |=> locked; endproperty
    property p_rd; key_rd_data == '0; endproperty
    property p_clear; reset_event |=> busy && aes_key == '0; endproperty
    property p_grant; go && service_req |=> service_grant; endproperty
    property p_refuse; key_wr.valid && !go |=> write_refused; endproperty
    property p_fifo;
        go && fifo_wr.valid && (fifo_wr.fifo & fifo_assigned) == '0 |=>
            write_refused;
    endproperty
    a_key: assert property (p_key) else $error("aes key not replaced");
    a_next: assert property (p_next) else $error("next check missing");
    a_done: assert property (p_done) else $error("not ready at end");
    a_lock: assert property (p_lock) else $error("fail did not lock");
    a_hold: assert property (p_hold) else $error("lock left");
    a_rd: assert property (p_rd) else $error("secret read not zero");
    a_clear: assert property (p_clear) else $error("keys kept");
    a_grant: assert property (p_grant) else $error("no grant");
    a_refuse: assert property (p_refuse) else $error("write kept");
    a_fifo: assert property (p_fifo) else $error("fifo write kept");
endmodule

// >>> sim/check_model.sv
// Purpose: Known-answer engines seen by the sequencer
// Assumes: One answer per start pulse
// Notes: Odd checks answer slowly; fail_idx picks a failing check
`timescale 1ns/1ps
module check_model (
    // Sequencer side
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire key_guard_pkg::check_req_t req,
    input wire logic [3:0] fail_idx,
    output logic done,
    output logic pass
);
    logic [1:0] cnt;
    logic [3:0] idx;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 2'h0;
            idx <= 4'h0;
            done <= 1'b0;
            pass <= 1'b0;
        end else begin
            done <= 1'b0;
            // Pass wobbles outside answers so a stale value is never read
            pass <= ~pass;
            if (req.start) begin
                cnt <= req.index[0] ? 2'h3 : 2'h1;
                idx <= req.index;
            end else if (cnt != 2'h0) begin
                cnt <= cnt - 2'h1;
                done <= cnt == 2'h1;
                if (cnt == 2'h1)
                    pass <= idx != fail_idx;
            end
        end
    end
endmodule

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the key guard
// Assumes: Inputs change 1 ns after rising edges
// Notes: Rows hold key and fifo writes with expected results
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic fifo;
        logic [1:0] slot;
        logic [3:0] sel;
        logic [255:0] data;
        logic refused;
    } row_t;
    row_t rows [6] = '{'{1'b0, 2'h0, 4'h0, 256'ha1, 1'b0},
        '{1'b1, 2'h1, 4'h1, 256'hb2, 1'b0}, '{1'b1, 2'h2, 4'h4, 256'hc3, 1'b1},
        '{1'b0, 2'h3, 4'h0, 256'hd4, 1'b0}, '{1'b0, 2'h0, 4'h0, 256'he5, 1'b0},
        '{1'b0, 2'h0, 4'h0, 256'hf6, 1'b1}};
    logic ref_clk, rst_b, reset_event, key_rd, service_req, service_grant;
    logic check_done, check_pass, busy, ready, locked, write_refused;
    key_guard_pkg::key_write_t key_wr;
    key_guard_pkg::fifo_write_t fifo_wr;
    key_guard_pkg::check_req_t check_req;
    logic [3:0] fifo_assigned, fail_idx;
    logic [1:0] key_rd_slot;
    logic [255:0] key_rd_data, kout [4];
    logic [8:0] checks_passed;
    int bad_count = 0;
    int check_count = 0;
    key_guard DUT (.ref_clk, .rst_b, .reset_event, .key_wr, .fifo_wr,
        .fifo_assigned, .key_rd, .key_rd_slot, .key_rd_data, .check_req,
        .check_done, .check_pass, .service_req, .service_grant, .busy, .ready,
        .locked, .checks_passed, .write_refused, .aes_key(kout[0]),
        .tdes_key(kout[1]), .hmac_key(kout[2]), .cmac_key(kout[3]));
    check_model u_model (.ref_clk, .rst_b, .req(check_req), .fail_idx,
        .done(check_done), .pass(check_pass));
    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end
    task chk(input string name, input logic [255:0] exp, got);
        check_count++;
        if (exp !== got) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    task finish_test;
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task step;
        @(posedge ref_clk);
        #1;
    endtask
    task wait_for(input logic lk);
        int n;
        for (n = 0; n < 300 && (lk ? locked : ready) !== 1'b1; n++) step;
        if (n == 300) begin
            $display("wrong value %s expected 1 seen 0",
                lk ? "locked" : "ready");
            bad_count++;
            finish_test;
        end
    endtask
    task pulse;
        reset_event = 1;
        step;
        reset_event = 0;
    endtask
    task wr(input row_t r);
        key_wr = '{!r.fifo, 1'b0, r.slot, r.data};
        fifo_wr = '{r.fifo, r.slot, r.sel, r.data};
        step;
        key_wr.valid = 0;
        fifo_wr.valid = 0;
        chk("refused", 256'(r.refused), 256'(write_refused));
        step;
        step;
        chk("key", r.refused ? '0 : r.data, kout[r.slot]);
    endtask
    initial begin
        {rst_b, reset_event, key_wr, fifo_wr, key_rd_slot} = '0;
        {key_rd, service_req, fifo_assigned, fail_idx} = 10'h3bf;
        repeat (5) @(posedge ref_clk);
        #1 rst_b = 1;
        chk("busy", 256'h1, 256'(busy));
        wait_for(0);
        step;
        chk("passed", 256'h1ff, 256'(checks_passed));
        chk("grant", 256'h1, 256'(service_grant));
        for (int i = 0; i < 5; i++) wr(rows[i]);
        chk("read", '0, key_rd_data);
        pulse;
        chk("clear", '0, kout[0] | kout[1] | kout[3]);
        wr(rows[5]);
        wait_for(0);
        fail_idx = 4'h5;
        repeat (2) begin
            pulse;
            wait_for(1);
            wr(rows[5]);
            chk("grant", '0, 256'(service_grant));
            chk("passed", 256'h01f, 256'(checks_passed));
        end
        fail_idx = 4'hf;
        pulse;
        wait_for(0);
        chk("locked", '0, 256'(locked));
        finish_test;
    end
endmodule
bind key_guard key_guard_sva u_sva (.ref_clk, .rst_b, .reset_event, .key_wr,
    .fifo_wr, .fifo_assigned, .key_rd_data, .check_req, .check_done,
    .check_pass, .service_req, .service_grant, .busy, .ready, .locked,
    .write_refused, .aes_key);
